// ===== hdl/csl_status.sv
`timescale 1ns/1ns
`include "csl_params.svh"
module csl_status
   import csl_pkg::*;
#(
   parameter int SLOW_CYC  = `CSL_SLOW_CYC,
   parameter int FAST_CYC  = `CSL_FAST_CYC,
   parameter int PROBE_CYC = `CSL_PROBE_CYC
) (
   input  wire logic        sys_clk,        // 25 MHz
   input  wire logic        reset_n,        // Sync reset
   input  wire logic        init_done,      // Firmware init complete
   input  wire logic        init_fault,     // Init problem
   input  wire logic        over_temp,      // Too hot
   input  wire logic        link_up,        // Ethernet link (async)
   input  wire logic        app_conn,       // Host application connected
   input  wire logic        acq_trig,       // Triggered acquisition
   input  wire logic        acq_free,       // Free-running acquisition
   input  wire logic        persist_en,     // Persistent address enable
   input  wire logic        dhcp_en,        // DHCP enable
   input  wire logic        factory_rst,    // Restore address defaults
   input  wire logic [31:0] persist_addr,   // Stored address
   input  wire logic        dhcp_offer,     // DHCP server answered
   input  wire logic [31:0] dhcp_addr,      // Offered address
   input  wire logic        dhcp_timeout,   // No DHCP server
   input  wire logic        arp_reply,      // Probe answered
   output logic             led_red,        // LED red drive
   output logic             led_green,      // LED green drive
   output logic             led_blue,       // LED blue drive
   output logic             arp_probe,      // Probe request pulse
   output logic             dhcp_req,       // DHCP request pulse
   output logic [31:0]      ip_addr,        // Current address
   output logic             host_ok         // Host traffic accepted
);
   import csl_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic link_m_q, link_q, link_d1_q;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         link_m_q  <= 1'b0;
         link_q    <= 1'b0;
         link_d1_q <= 1'b0;
      end else begin
         link_m_q  <= link_up;
         link_q    <= link_m_q;
         link_d1_q <= link_q;
      end
   end
   wire link_rise = link_q & ~link_d1_q;

   // ------------------------------------------------------------
   // Address option flags
   // ------------------------------------------------------------
   logic persist_q, dhcp_q;
   always_ff @(posedge sys_clk) begin
      if (!reset_n || factory_rst) begin
         persist_q <= `CSL_PERSIST_RST;
         dhcp_q    <= `CSL_DHCP_RST;
      end else begin
         persist_q <= persist_en;
         dhcp_q    <= dhcp_en;
      end
   end

   // ------------------------------------------------------------
   // Blink generators
   // ------------------------------------------------------------
   logic [31:0] slow_cnt_q, fast_cnt_q;
   logic        slow_ph_q, fast_ph_q;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         slow_cnt_q <= 32'h0;
         slow_ph_q  <= 1'b1;
      end else if (slow_cnt_q == 32'(SLOW_CYC - 1)) begin
         slow_cnt_q <= 32'h0;
         slow_ph_q  <= ~slow_ph_q;
      end else begin
         slow_cnt_q <= slow_cnt_q + 32'h1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         fast_cnt_q <= 32'h0;
         fast_ph_q  <= 1'b1;
      end else if (fast_cnt_q == 32'(FAST_CYC - 1)) begin
         fast_cnt_q <= 32'h0;
         fast_ph_q  <= ~fast_ph_q;
      end else begin
         fast_cnt_q <= fast_cnt_q + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // Address acquisition
   // ------------------------------------------------------------
   csl_acq_e    st_q;
   logic        boot_q;
   logic [15:0] lfsr_q;
   logic [31:0] probe_cnt_q;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) lfsr_q <= `CSL_LFSR_SEED;
      else lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
   end
   wire [15:0] lla_lo = (lfsr_q < `CSL_LLA_LO_MIN) ? (lfsr_q | `CSL_LLA_LO_MIN) :
                        (lfsr_q > `CSL_LLA_LO_MAX) ? (lfsr_q & 16'hfeff) : lfsr_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st_q        <= CSL_A_IDLE;
         boot_q      <= 1'b1;
         ip_addr     <= 32'h0;
         arp_probe   <= 1'b0;
         dhcp_req    <= 1'b0;
         probe_cnt_q <= 32'h0;
      end else begin
         arp_probe <= 1'b0;
         dhcp_req  <= 1'b0;
         boot_q    <= 1'b0;
         if (!link_q) begin
            st_q    <= CSL_A_NOLINK;
            ip_addr <= 32'h0;
         end else if (boot_q || link_rise) begin
            st_q <= CSL_A_PERSIST;
         end else begin
            case (st_q)
               CSL_A_PERSIST: begin
                  if (persist_q) begin
                     ip_addr <= persist_addr;
                     st_q    <= CSL_A_DONE;
                  end else if (dhcp_q) begin
                     dhcp_req <= 1'b1;
                     st_q     <= CSL_A_DHCP;
                  end else begin
                     st_q <= CSL_A_PICK;
                  end
               end
               CSL_A_DHCP: begin
                  if (dhcp_offer) begin
                     ip_addr <= dhcp_addr;
                     st_q    <= CSL_A_DONE;
                  end else if (dhcp_timeout) begin
                     st_q <= CSL_A_PICK;
                  end
               end
               CSL_A_PICK: begin
                  ip_addr     <= {`CSL_LLA_PREFIX, lla_lo};
                  arp_probe   <= 1'b1;
                  probe_cnt_q <= 32'h0;
                  st_q        <= CSL_A_PROBE;
               end
               CSL_A_PROBE: begin
                  if (arp_reply) begin
                     st_q <= CSL_A_PICK;
                  end else if (probe_cnt_q == 32'(PROBE_CYC - 1)) begin
                     st_q <= CSL_A_DONE;
                  end else begin
                     probe_cnt_q <= probe_cnt_q + 32'h1;
                  end
               end
               CSL_A_DONE, CSL_A_IDLE, CSL_A_NOLINK: st_q <= st_q;
               default: st_q <= CSL_A_IDLE;
            endcase
         end
      end
   end
   wire assigned = (st_q == CSL_A_DONE);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) host_ok <= 1'b0;
      else host_ok <= assigned & link_q;
   end

   // ------------------------------------------------------------
   // Priority encoder, highest first
   // ------------------------------------------------------------
   csl_color_e col;
   csl_blink_e blk;
   always_comb begin
      col = CSL_RED;
      blk = CSL_STEADY;
      if (over_temp) begin
         col = CSL_RED; blk = CSL_FAST;
      end else if (init_fault) begin
         col = CSL_RED; blk = CSL_SLOW;
      end else if (!init_done) begin
         col = CSL_RED; blk = CSL_STEADY;
      end else if (!link_q) begin
         col = CSL_BLUE; blk = CSL_FAST;
      end else if (!assigned) begin
         col = CSL_BLUE; blk = CSL_SLOW;
      end else if (acq_free) begin
         col = CSL_GREEN; blk = CSL_FAST;
      end else if (acq_trig) begin
         col = CSL_GREEN; blk = CSL_SLOW;
      end else if (app_conn) begin
         col = CSL_GREEN; blk = CSL_STEADY;
      end else begin
         col = CSL_BLUE; blk = CSL_STEADY;
      end
   end
   wire lit = (blk == CSL_STEADY) | (blk == CSL_SLOW & slow_ph_q) |
              (blk == CSL_FAST & fast_ph_q);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         led_red   <= 1'b0;
         led_green <= 1'b0;
         led_blue  <= 1'b0;
      end else begin
         led_red   <= lit & (col == CSL_RED);
         led_green <= lit & (col == CSL_GREEN);
         led_blue  <= lit & (col == CSL_BLUE);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_reset_led_off: assert property (@(posedge sys_clk)
      !reset_n |=> !led_red && !led_green && !led_blue)
      else $error("LED lit during reset");
   a_red_after_rst: assert property (@(posedge sys_clk)
      $rose(reset_n) && !init_done && !over_temp && !init_fault |=> led_red)
      else $error("No red after reset");
   a_host_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
      host_ok |-> $past(st_q) == CSL_A_DONE)
      else $error("Host accepted before address");
   a_lla_prefix: assert property (@(posedge sys_clk) disable iff (!reset_n)
      arp_probe |-> ip_addr[31:16] == `CSL_LLA_PREFIX)
      else $error("Probe outside link-local subnet");
   a_persist_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q == CSL_A_PERSIST && persist_q && link_q && !link_rise |=> st_q == CSL_A_DONE)
      else $error("Persistent address skipped");
   a_link_restart: assert property (@(posedge sys_clk) disable iff (!reset_n)
      link_rise |=> st_q == CSL_A_PERSIST)
      else $error("No restart on link-up");
   a_nolink_blue: assert property (@(posedge sys_clk) disable iff (!reset_n)
      init_done && !init_fault && !over_temp && !link_q |=> !led_red && !led_green)
      else $error("No-link colour wrong");
   a_free_green: assert property (@(posedge sys_clk) disable iff (!reset_n)
      init_done && !init_fault && !over_temp && link_q && assigned && acq_free
      |=> !led_blue && !led_red)
      else $error("Acquisition not shown over address");
endmodule // csl_status

// ===== hdl/csl_params.svh
// Notes on behaviour
// - Only the highest-priority active condition shows; acquisition outranks address assigned.
// - Steady red uninitialised, slow red init fault, fast red over temperature.
// - Slow blue while waiting for a network address.
// - Fast blue while no Ethernet link is present.
// - Steady blue once address assigned and no host application connected.
// - Steady green connected; slow green triggered, fast green free-running acquisition.
// - Host traffic accepted only after address assignment; host waits for it.
// - Address acquisition starts at power-up and on every link-up.
// - Order: persistent if enabled, then DHCP if answered, then link-local.
// - Factory default: persistent off, DHCP on; link-local always on.
// - Link-local: random 169.254 address, ARP probe, retry if answered.
`ifndef CSL_PARAMS_SVH
`define CSL_PARAMS_SVH

// ------------------------------------------------------------
// Timing at 25 MHz
// ------------------------------------------------------------
`define CSL_CLK_HZ        25000000
`define CSL_SLOW_MS       500
`define CSL_FAST_MS       125
`define CSL_SLOW_CYC      ((`CSL_CLK_HZ / 1000) * `CSL_SLOW_MS)
`define CSL_FAST_CYC      ((`CSL_CLK_HZ / 1000) * `CSL_FAST_MS)
`define CSL_PROBE_MS      200
`define CSL_PROBE_CYC     ((`CSL_CLK_HZ / 1000) * `CSL_PROBE_MS)

// ------------------------------------------------------------
// Defaults and address fields
// ------------------------------------------------------------
`define CSL_PERSIST_RST   1'b0
`define CSL_DHCP_RST      1'b1
`define CSL_LLA_PREFIX    16'ha9fe
`define CSL_LLA_LO_MIN    16'h0100
`define CSL_LLA_LO_MAX    16'hfeff
`define CSL_LFSR_SEED     16'hace1
`endif

// ===== hdl/csl_pkg.sv
package csl_pkg;
   typedef enum logic [1:0] {
      CSL_OFF   = 2'b00,
      CSL_RED   = 2'b01,
      CSL_GREEN = 2'b10,
      CSL_BLUE  = 2'b11
   } csl_color_e;

   typedef enum logic [1:0] {
      CSL_STEADY = 2'b00,
      CSL_SLOW   = 2'b01,
      CSL_FAST   = 2'b10
   } csl_blink_e;

   typedef enum logic [2:0] {
      CSL_A_IDLE    = 3'b000,
      CSL_A_PERSIST = 3'b001,
      CSL_A_DHCP    = 3'b010,
      CSL_A_PICK    = 3'b011,
      CSL_A_PROBE   = 3'b100,
      CSL_A_DONE    = 3'b101,
      CSL_A_NOLINK  = 3'b110
   } csl_acq_e;
endpackage

// ===== dv/csl_net_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Network partner: DHCP server and address owners
// ------------------------------------------------------------
module csl_net_model #(
   parameter logic [31:0] OFFER_ADDR = 32'h0a000105,
   parameter int          OFFER_DLY  = 80
) (
   input  wire logic        sys_clk,      // Clock
   input  wire logic        reset_n,      // Sync reset
   input  wire logic        dhcp_req,     // Request from device
   input  wire logic        arp_probe,    // Probe from device
   input  wire logic        server_on,    // DHCP server present
   input  wire logic [31:0] arp_answers,  // Probes answered while below
   output logic             dhcp_offer,   // Offer pulse
   output logic [31:0]      dhcp_addr,    // Offered address
   output logic             dhcp_timeout, // No server pulse
   output logic             arp_reply,    // Address in use
   output int               n_dhcp,       // Requests seen
   output int               n_probe       // Probes seen
);
   int         wait_q;
   logic       pend_q;
   logic [2:0] arp_q;
   // Stale value would hide a missed qualifier, so show its inverse
   assign dhcp_addr = dhcp_offer ? OFFER_ADDR : ~OFFER_ADDR;
   always_ff @(posedge sys_clk) begin
      dhcp_offer <= 1'b0;
      dhcp_timeout <= 1'b0;
      if (!reset_n) begin
         pend_q <= 1'b0;
         n_dhcp <= 0;
      end else if (dhcp_req) begin
         pend_q <= 1'b1;
         wait_q <= OFFER_DLY;
         n_dhcp <= n_dhcp + 1;
      end else if (pend_q && wait_q == 0) begin
         pend_q <= 1'b0;
         dhcp_offer <= server_on;
         dhcp_timeout <= !server_on;
      end else if (pend_q) begin
         wait_q <= wait_q - 1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         arp_q <= 3'h0;
         n_probe <= 0;
      end else begin
         arp_q <= {arp_q[1:0], arp_probe && (n_probe < arp_answers)};
         n_probe <= n_probe + int'(arp_probe);
      end
   end
   assign arp_reply = arp_q[2];
endmodule // csl_net_model

// ===== dv/camera_status_led_ip_config_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t: %s", $time, m); end end
module camera_status_led_ip_config_tb_top;
   import csl_pkg::*;
   logic        sys_clk = 0, reset_n = 0, init_done = 0, init_fault = 0, over_temp = 0;
   logic        link_up = 0, app_conn = 0, acq_trig = 0, acq_free = 0, persist_en = 0;
   logic        dhcp_en = 1, factory_rst = 0, server_on = 1;
   logic [31:0] persist_addr = 32'hc0a80a07, dhcp_addr, ip_addr;
   logic        dhcp_offer, dhcp_timeout, arp_reply, arp_probe, dhcp_req, host_ok;
   logic        led_red, led_green, led_blue;
   int          arp_answers = 0, n_dhcp, n_probe, num_errors = 0, num_checks = 0, d0, p0;
   // ------------------------------------------------------------
   // Clock, design and partner
   // ------------------------------------------------------------
   initial forever #20 sys_clk = ~sys_clk;
   csl_status #(.SLOW_CYC(8), .FAST_CYC(2), .PROBE_CYC(16)) DUT (
      .sys_clk(sys_clk), .reset_n(reset_n), .init_done(init_done), .init_fault(init_fault),
      .over_temp(over_temp), .link_up(link_up), .app_conn(app_conn), .acq_trig(acq_trig),
      .acq_free(acq_free), .persist_en(persist_en), .dhcp_en(dhcp_en),
      .factory_rst(factory_rst), .persist_addr(persist_addr), .dhcp_offer(dhcp_offer),
      .dhcp_addr(dhcp_addr), .dhcp_timeout(dhcp_timeout), .arp_reply(arp_reply),
      .led_red(led_red), .led_green(led_green), .led_blue(led_blue), .arp_probe(arp_probe),
      .dhcp_req(dhcp_req), .ip_addr(ip_addr), .host_ok(host_ok));
   csl_net_model NET (
      .sys_clk(sys_clk), .reset_n(reset_n), .dhcp_req(dhcp_req), .arp_probe(arp_probe),
      .server_on(server_on), .arp_answers(arp_answers), .dhcp_offer(dhcp_offer),
      .dhcp_addr(dhcp_addr), .dhcp_timeout(dhcp_timeout), .arp_reply(arp_reply),
      .n_dhcp(n_dhcp), .n_probe(n_probe));
   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Mask is {red, green, blue}; b: 0 steady, 1 slow, 2 fast
   task automatic check_led(input logic [2:0] m, input int b);
      int   lit = 0, bad = 0, tog = 0;
      logic now, was;
      for (int i = 0; i < 32; i++) begin
         @(posedge sys_clk);
         #1;
         now = |({led_red, led_green, led_blue} & m);
         bad += int'(|({led_red, led_green, led_blue} & ~m));
         lit += int'(now);
         if (i > 0 && now !== was) tog++;
         was = now;
      end
      `CHK(bad, 0, "wrong colour lit")
      if (b == 0) `CHK(lit, 32, "steady light broken")
      if (b == 1) `CHK(tog inside {[2:5]}, 1'b1, "slow flash rate")
      if (b == 2) `CHK(tog > 11, 1'b1, "fast flash rate")
      // Hand back on a rising edge so the next stimulus lands there
      @(posedge sys_clk);
   endtask
   task automatic wait_ok();
      for (int i = 0; i < 600 && host_ok !== 1'b1; i++) @(posedge sys_clk);
      `CHK(host_ok, 1'b1, "no address assigned")
   endtask
   task automatic relink();
      @(posedge sys_clk);
      link_up <= 1'b0;
      cyc(8);
      link_up <= 1'b1;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      cyc(15);
      #1;
      `CHK({led_red, led_green, led_blue}, 3'b000, "lit in reset")
      @(posedge sys_clk);
      reset_n <= 1'b1;
      cyc(2);
      check_led(3'b100, 0);
   endtask
   task automatic t_faults();
      init_fault <= 1'b1;
      cyc(3);
      check_led(3'b100, 1);
      over_temp <= 1'b1;
      cyc(3);
      check_led(3'b100, 2);
      init_fault <= 1'b0;
      over_temp <= 1'b0;
      init_done <= 1'b1;
      cyc(6);
      check_led(3'b001, 2);
   endtask
   task automatic t_dhcp();
      link_up <= 1'b1;
      cyc(8);
      check_led(3'b001, 1);
      `CHK(host_ok, 1'b0, "host accepted early")
      `CHK(n_dhcp, 1, "no request on link rise")
      wait_ok();
      `CHK(ip_addr, 32'h0a000105, "offered address")
      check_led(3'b001, 0);
   endtask
   task automatic t_acq();
      app_conn <= 1'b1;
      cyc(3);
      check_led(3'b010, 0);
      acq_trig <= 1'b1;
      cyc(3);
      check_led(3'b010, 1);
      acq_free <= 1'b1;
      cyc(3);
      check_led(3'b010, 2);
      {app_conn, acq_trig, acq_free} <= 3'b000;
   endtask
   task automatic t_lla();
      server_on <= 1'b0;
      arp_answers <= n_probe + 1;
      d0 = n_dhcp;
      p0 = n_probe;
      link_up <= 1'b0;
      cyc(6);
      `CHK({host_ok, ip_addr}, 33'h0, "address kept without link")
      link_up <= 1'b1;
      wait_ok();
      `CHK(n_dhcp, d0 + 1, "server not tried first")
      `CHK(n_probe, p0 + 2, "answered probe not retried")
      `CHK(ip_addr[31:16], 16'ha9fe, "link-local prefix")
   endtask
   task automatic t_persist();
      server_on <= 1'b1;
      persist_en <= 1'b1;
      d0 = n_dhcp;
      relink();
      wait_ok();
      `CHK(ip_addr, persist_addr, "stored address")
      `CHK(n_dhcp, d0, "server asked needlessly")
      factory_rst <= 1'b1;
      dhcp_en <= 1'b0;
      relink();
      wait_ok();
      `CHK(ip_addr, 32'h0a000105, "defaults not restored")
      `CHK(n_dhcp, d0 + 1, "server not asked")
   endtask
   initial begin
      t_reset();
      t_faults();
      t_dhcp();
      t_acq();
      t_lla();
      t_persist();
      print_verdict();
   end
   initial begin
      cyc(20000);
      num_errors++;
      print_verdict();
   end
endmodule // camera_status_led_ip_config_tb_top
